// file: rtl/cic_cfg.svh
// register map, field positions, reset values and timing counts of the interrupt controller
`ifndef CIC_CFG_SVH
`define CIC_CFG_SVH

`define CIC_NUM_SRC         10
`define CIC_ADDR_IEN_FIRST  8'hA8
`define CIC_ADDR_IEN_SECOND 8'hB8
`define CIC_ADDR_IEN_THIRD  8'h9A
`define CIC_ADDR_PRI0       8'hA9
`define CIC_ADDR_PRI1       8'hB9
`define CIC_ADDR_PRI2       8'hBA
`define CIC_ADDR_FLAG_LO    8'hC0
`define CIC_ADDR_FLAG_HI    8'hC1
`define CIC_ADDR_WAKE       8'hC2
`define CIC_ADDR_SERVICE    8'hC3

`define CIC_RST_IEN         8'h00
`define CIC_RST_PRI         8'h00
`define CIC_RST_FLAGS       10'h000
`define CIC_RST_VEC         16'h0000

`define CIC_BIT_GLOBAL      7
`define CIC_BIT_NON_IRQ     6
`define CIC_BIT_SER0        4
`define CIC_BIT_TMR1        3
`define CIC_BIT_EXT1        2
`define CIC_BIT_TMR0        1
`define CIC_BIT_EXT0        0
`define CIC_BIT_REROUTE     0

// sources whose flag the hardware clears when the call is forced
`define CIC_HW_CLEAR_MASK   10'h1EF

`define CIC_VEC_BASE        16'h0003
`define CIC_VEC_STEP        16'h0008

`define CIC_MC_CLKS         12
`define CIC_CALL_MC         6
`define CIC_WAKE_DLY_CLKS   512

`endif

// file: rtl/cic_core.sv
// interrupt controller: flags, enables, priorities, arbitration and forced call sequencing
//
// Function
// - ten interrupt sources, each given one of four priority levels.
// - each source has request flags held apart from its enable bits.
// - each source is masked alone by a bit in one of three enable registers.
// - source nine merges three causes, each with its own flag and enable.
// - peripheral events outside the processor core feed the external sources.
// - an accepted interrupt branches to the fixed vector of its source.
// - a running service is preempted only by a strictly higher level.
// - a request at or below the running level waits pending.
// - return from interrupt ends the service at its level.
// - a flag sets on its event whether or not the source is enabled.
// - flags are sampled once a machine cycle, then samples are polled.
// - a polled request is taken at the next instruction start with forced call.
// - least latency is one detect cycle plus six call machine cycles.
// - first enable register lives at A8 and resets to zero.
// - bit 7 of first enable register blocks every interrupt when zero.
// - bit 4 of first enable register gates serial channel 0.
// - bit 3 gates timer 1 overflow, bit 1 gates timer 0 overflow.
// - bit 2 gates external interrupt 1, bit 0 gates external interrupt 0.
// - bit 6 has no effect on gating; bit 5 is unassigned.
// - rerouted wake events raise external interrupt 0 after 512 clocks.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "cic_cfg.svh"

module cic_core
  import cic_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // interrupt sources
  input  wire logic [1:0]  ext_pin_n_i,
  input  wire logic [1:0]  tmr_ovf_i,
  input  wire logic        ser_evt_i,
  input  wire logic [3:0]  per_evt_i,
  input  wire logic [2:0]  mux_evt_i,
  input  wire logic        wake_evt_i,
  // processor core sequencer
  input  wire logic        instr_start_i,
  input  wire logic        return_from_interrupt_instr_i,
  output logic             forced_long_call_o,
  output logic             forced_long_call_busy_o,
  output logic      [15:0] vector_o,
  output logic      [3:0]  in_service_o
);

  localparam int NSRC = `CIC_NUM_SRC;

  // register file
  logic [7:0]      ien_first_ff;
  logic [7:0]      ien_second_ff;
  logic [7:0]      ien_third_ff;
  logic [7:0]      pri0_ff;
  logic [7:0]      pri1_ff;
  logic [7:0]      pri2_ff;
  logic            reroute_ff;
  logic [NSRC-2:0] flag_ff;
  logic [2:0]      cause_ff;

  // pin synchronisers and edge detect
  logic [1:0]      pin_s1_ff;
  logic [1:0]      pin_s2_ff;
  logic [1:0]      pin_s3_ff;
  logic [1:0]      pin_lvl_ff;
  logic [1:0]      pin_fall;

  // sampling and sequencing
  logic [3:0]      mc_cnt_ff;
  logic            mc_tick;
  logic [NSRC-1:0] smp_ff;
  cic_state_e      state_ff;
  cic_state_e      nxt_state;
  logic [2:0]      call_cnt_ff;
  logic [3:0]      isv_ff;
  logic            forced_long_call_ff;
  logic [15:0]     vec_ff;
  logic [7:0]      rdata_ff;

  // wake reroute delay
  logic            wake_run_ff;
  logic [9:0]      wake_cnt_ff;
  logic            wake_fire;

  // decode
  wire wr_interrupt_enable_second  = reg_wr_i && (reg_addr_i == `CIC_ADDR_IEN_FIRST);
  wire wr_interrupt_enable_third  = reg_wr_i && (reg_addr_i == `CIC_ADDR_IEN_SECOND);
  wire wr_ien3  = reg_wr_i && (reg_addr_i == `CIC_ADDR_IEN_THIRD);
  wire wr_pri0  = reg_wr_i && (reg_addr_i == `CIC_ADDR_PRI0);
  wire wr_pri1  = reg_wr_i && (reg_addr_i == `CIC_ADDR_PRI1);
  wire wr_pri2  = reg_wr_i && (reg_addr_i == `CIC_ADDR_PRI2);
  wire wr_flo   = reg_wr_i && (reg_addr_i == `CIC_ADDR_FLAG_LO);
  wire wr_fhi   = reg_wr_i && (reg_addr_i == `CIC_ADDR_FLAG_HI);
  wire wr_wake  = reg_wr_i && (reg_addr_i == `CIC_ADDR_WAKE);
  wire rd_wake  = reg_rd_i && (reg_addr_i == `CIC_ADDR_WAKE);

  // per-pin three-stage synchroniser; a change counts once stages two and three agree
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_pin
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
        begin
          pin_s1_ff[gp]  <= 1'b1;
          pin_s2_ff[gp]  <= 1'b1;
          pin_s3_ff[gp]  <= 1'b1;
          pin_lvl_ff[gp] <= 1'b1;
        end
        else
        begin
          pin_s1_ff[gp] <= ext_pin_n_i[gp];
          pin_s2_ff[gp] <= pin_s1_ff[gp];
          pin_s3_ff[gp] <= pin_s2_ff[gp];
          if (pin_s2_ff[gp] == pin_s3_ff[gp])
            pin_lvl_ff[gp] <= pin_s3_ff[gp];
        end
      end
      // falling edge of the agreed level requests the source
      assign pin_fall[gp] = pin_lvl_ff[gp] && !pin_s3_ff[gp]
                            && (pin_s2_ff[gp] == pin_s3_ff[gp]);
    end
  endgenerate

  // event per source in core order: ext0, tmr0, ext1, tmr1, serial, four peripherals
  wire [NSRC-2:0] evt = {per_evt_i, ser_evt_i, tmr_ovf_i[1], pin_fall[1],
                         tmr_ovf_i[0], pin_fall[0] | wake_fire};

  // flag view with the merged source folded in
  wire [NSRC-1:0] flags = {|(cause_ff & ien_third_ff[2:0]), flag_ff};

  // per-source enables: the first register's low bits line up with sources 0 to 4
  wire [NSRC-1:0] src_en = {ien_second_ff[4:0],
                            ien_first_ff[`CIC_BIT_SER0],
                            ien_first_ff[`CIC_BIT_TMR1],
                            ien_first_ff[`CIC_BIT_EXT1],
                            ien_first_ff[`CIC_BIT_TMR0],
                            ien_first_ff[`CIC_BIT_EXT0]};
  wire            global_en = ien_first_ff[`CIC_BIT_GLOBAL];
  wire [23:0]     pri_all   = {pri2_ff, pri1_ff, pri0_ff};
  wire [NSRC-1:0] pend      = smp_ff & src_en;

  // arbitration: highest level wins, lowest index breaks a tie
  logic     found;
  cic_lvl_t best_lvl;
  logic [3:0] best_idx;
  always_comb
  begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_idx = 4'h0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (pend[i] && (!found || (pri_all[2*i +: 2] > best_lvl)))
      begin
        found    = 1'b1;
        best_lvl = pri_all[2*i +: 2];
        best_idx = 4'(i);
      end
    end
  end

  // any level at or above the candidate in service blocks it
  wire [3:0] isv_at_or_above = isv_ff >> best_lvl;
  wire       grant = found && global_en && (isv_at_or_above == 4'h0);
  wire       take  = grant && instr_start_i && (state_ff == CIC_IDLE);

  wire [3:0]      take_lvl_1h = take ? (4'h1 << best_lvl) : 4'h0;
  wire [NSRC-1:0] take_src_1h = take ? (10'h001 << best_idx) : 10'h000;
  wire [NSRC-1:0] hw_ack      = take_src_1h & `CIC_HW_CLEAR_MASK;

  // highest level currently in service, released by return
  logic [3:0] top_isv;
  always_comb
  begin
    top_isv = 4'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (isv_ff[l])
        top_isv = 4'h1 << l;
    end
  end
  wire [3:0] return_from_interrupt_instr_clr = return_from_interrupt_instr_i ? top_isv : 4'h0;

  // vector of the winner
  wire [15:0] vec_new = `CIC_VEC_BASE + (16'(best_idx) * `CIC_VEC_STEP);

  // flag next values; the hardware set wins over a clear in the same cycle
  wire [NSRC-2:0] flag_wr  = {wr_fhi ? reg_wdata_i[0] : flag_ff[8],
                              wr_flo ? reg_wdata_i : flag_ff[7:0]};
  wire [NSRC-2:0] nxt_flag = (flag_wr & ~hw_ack[NSRC-2:0]) | evt;
  wire [2:0]      nxt_cause = (wr_fhi ? reg_wdata_i[3:1] : cause_ff) | mux_evt_i;

  // machine cycle tick
  assign mc_tick = (mc_cnt_ff == 4'(`CIC_MC_CLKS - 1));

  // wake reroute: fires ext0 a fixed delay after a rerouted wake event
  assign wake_fire = wake_run_ff && (wake_cnt_ff == 10'(`CIC_WAKE_DLY_CLKS - 1));

  // call sequencing
  wire call_done = mc_tick && (call_cnt_ff == 3'(`CIC_CALL_MC - 1));
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      CIC_IDLE: if (take)      nxt_state = CIC_CALL;
      CIC_CALL: if (call_done) nxt_state = CIC_IDLE;
    endcase
  end

  // read mux; unmapped addresses answer zero
  wire [7:0] rd_mux =
    (reg_addr_i == `CIC_ADDR_IEN_FIRST)  ? {ien_first_ff[7:6], 1'b0, ien_first_ff[4:0]} :
    (reg_addr_i == `CIC_ADDR_IEN_SECOND) ? ien_second_ff :
    (reg_addr_i == `CIC_ADDR_IEN_THIRD)  ? ien_third_ff :
    (reg_addr_i == `CIC_ADDR_PRI0)       ? pri0_ff :
    (reg_addr_i == `CIC_ADDR_PRI1)       ? pri1_ff :
    (reg_addr_i == `CIC_ADDR_PRI2)       ? {4'h0, pri2_ff[3:0]} :
    (reg_addr_i == `CIC_ADDR_FLAG_LO)    ? flag_ff[7:0] :
    (reg_addr_i == `CIC_ADDR_FLAG_HI)    ? {4'h0, cause_ff, flag_ff[8]} :
    (reg_addr_i == `CIC_ADDR_WAKE)       ? {7'h00, reroute_ff} :
    (reg_addr_i == `CIC_ADDR_SERVICE)    ? {3'h0, forced_long_call_busy_o, isv_ff} :
                                           8'h00;

  // enable and priority registers
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ien_first_ff  <= `CIC_RST_IEN;
      ien_second_ff <= `CIC_RST_IEN;
      ien_third_ff  <= `CIC_RST_IEN;
      pri0_ff       <= `CIC_RST_PRI;
      pri1_ff       <= `CIC_RST_PRI;
      pri2_ff       <= `CIC_RST_PRI;
    end
    else
    begin
      // bit 6 is stored for software but never gates; bit 5 is not kept
      if (wr_interrupt_enable_second) ien_first_ff  <= reg_wdata_i & 8'hDF;
      if (wr_interrupt_enable_third) ien_second_ff <= reg_wdata_i & 8'h1F;
      if (wr_ien3) ien_third_ff  <= reg_wdata_i & 8'h07;
      if (wr_pri0) pri0_ff       <= reg_wdata_i;
      if (wr_pri1) pri1_ff       <= reg_wdata_i;
      if (wr_pri2) pri2_ff       <= reg_wdata_i & 8'h0F;
    end
  end

  // request flags
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      flag_ff  <= 9'h000;
      cause_ff <= 3'h0;
    end
    else
    begin
      flag_ff  <= nxt_flag;
      cause_ff <= nxt_cause;
    end
  end

  // machine cycle counter and flag samples
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      mc_cnt_ff <= 4'h0;
      smp_ff    <= `CIC_RST_FLAGS;
    end
    else
    begin
      mc_cnt_ff <= mc_tick ? 4'h0 : mc_cnt_ff + 4'h1;
      // a taken source drops out at once so it cannot be taken twice
      if (mc_tick)
        smp_ff <= flags & ~take_src_1h;
      else
        smp_ff <= smp_ff & ~take_src_1h;
    end
  end

  // wake reroute; reading its register clears the enable
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      reroute_ff  <= 1'b0;
      wake_run_ff <= 1'b0;
      wake_cnt_ff <= 10'h000;
    end
    else
    begin
      if (wr_wake)
        reroute_ff <= reg_wdata_i[`CIC_BIT_REROUTE];
      else if (rd_wake)
        reroute_ff <= 1'b0;
      if (wake_fire)
        wake_run_ff <= 1'b0;
      else if (wake_evt_i && reroute_ff && !wake_run_ff)
        wake_run_ff <= 1'b1;
      wake_cnt_ff <= wake_run_ff ? wake_cnt_ff + 10'h001 : 10'h000;
    end
  end

  // service sequencing
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_ff    <= CIC_IDLE;
      call_cnt_ff <= 3'h0;
      isv_ff      <= 4'h0;
      forced_long_call_ff    <= 1'b0;
      vec_ff      <= `CIC_RST_VEC;
    end
    else
    begin
      state_ff    <= nxt_state;
      forced_long_call_ff    <= take;
      isv_ff      <= (isv_ff & ~return_from_interrupt_instr_clr) | take_lvl_1h;
      if (take)
        vec_ff <= vec_new;
      if (state_ff != CIC_CALL)
        call_cnt_ff <= 3'h0;
      else if (mc_tick)
        call_cnt_ff <= call_cnt_ff + 3'h1;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
  end

  assign reg_rdata_o  = rdata_ff;
  assign forced_long_call_o      = forced_long_call_ff;
  assign forced_long_call_busy_o = (state_ff == CIC_CALL);
  assign vector_o     = vec_ff;
  assign in_service_o = isv_ff;

endmodule // cic_core

// file: rtl/cic_pkg.sv
// types shared by the interrupt controller
package cic_pkg;

  typedef enum logic [0:0] {
    CIC_IDLE,
    CIC_CALL
  } cic_state_e;

  typedef logic [1:0] cic_lvl_t;

endpackage

// file: tb/cic_core_monitor.sv
// port-level assertion checker for the interrupt controller
`timescale 1ns/1ps
module cic_core_monitor (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  // core sequencer side
  input wire logic        instr_start_i,
  input wire logic        return_from_interrupt_instr_i,
  input wire logic        forced_long_call_o,
  input wire logic        forced_long_call_busy_o,
  input wire logic [15:0] vector_o,
  input wire logic [3:0]  in_service_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] ien_ff;
  logic [6:0] blen_ff;
  wire        ien_wr = reg_wr_i && reg_addr_i == 8'hA8;
  // shadow of the first enable register and length of the current call
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ien_ff  <= 8'h00;
      blen_ff <= 7'h00;
    end
    else
    begin
      if (ien_wr)
        ien_ff <= reg_wdata_i;
      blen_ff <= forced_long_call_busy_o ? blen_ff + 7'h01 : 7'h00;
    end
  end
  AST_CALL_ONE_CYCLE: assert property (forced_long_call_o |=> !forced_long_call_o)
    else $error("forced call pulse longer than one cycle");
  AST_CALL_AT_START: assert property (forced_long_call_o |-> $past(instr_start_i))
    else $error("forced call without instruction start");
  AST_CALL_GLOBAL: assert property (forced_long_call_o |-> $past(ien_ff[7]))
    else $error("interrupt taken while globally masked");
  AST_CALL_IDLE: assert property (forced_long_call_o |-> forced_long_call_busy_o && !$past(forced_long_call_busy_o))
    else $error("call issued while a call was running");
  // the first tick may come anywhere in a 12-clock machine cycle
  AST_BUSY_SPAN: assert property ($fell(forced_long_call_busy_o) |-> blen_ff inside {[60:73]})
    else $error("forced call length outside six machine cycles");
  AST_VECTOR: assert property (forced_long_call_o |-> vector_o[2:0] == 3'h3 && vector_o <= 16'h004B)
    else $error("vector not a source entry");
  AST_PREEMPT: assert property (forced_long_call_o |->
    (in_service_o ^ $past(in_service_o)) > $past(in_service_o))
    else $error("new service not above running level");
  AST_RETURN_FROM_INTERRUPT_INSTR: assert property (return_from_interrupt_instr_i && !instr_start_i && in_service_o != 4'h0 |=>
    $countones(in_service_o) + 1 == $countones($past(in_service_o)))
    else $error("return did not end one service level");
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  AST_IEN_READ: assert property ($past(reg_rd_i && reg_addr_i == 8'hA8) |->
    reg_rdata_o == ($past(ien_ff) & 8'hDF))
    else $error("enable register read mismatch");
  cover property (forced_long_call_o && $past(in_service_o) != 4'h0);
  cover property ($fell(forced_long_call_busy_o));
  cover property (return_from_interrupt_instr_i && in_service_o != 4'h0);
endmodule // cic_core_monitor

bind cic_core cic_core_monitor mon (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .instr_start_i, .return_from_interrupt_instr_i, .forced_long_call_o, .forced_long_call_busy_o,
  .vector_o, .in_service_o);

// file: tb/cic_core_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module cic_core_tb;
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic [7:0]  wd       = 8'h00;
  logic        wr_s     = 1'b0;
  logic        rd_s     = 1'b0;
  logic [1:0]  ext_n    = 2'h3;
  logic [1:0]  tmr      = 2'h0;
  logic        ser      = 1'b0;
  logic [3:0]  per      = 4'h0;
  logic [2:0]  mux      = 3'h0;
  logic        wake     = 1'b0;
  logic        return_from_interrupt_instr_req = 1'b0;
  logic        istart, return_from_interrupt_instr, forced_long_call, busy, seen;
  logic [7:0]  rdata;
  logic [15:0] vec;
  logic [3:0]  isv;
  int          errors   = 0;
  int          n_checks = 0;
  cic_core uut (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .ext_pin_n_i(ext_n),
    .tmr_ovf_i(tmr), .ser_evt_i(ser), .per_evt_i(per), .mux_evt_i(mux),
    .wake_evt_i(wake), .instr_start_i(istart), .return_from_interrupt_instr_i(return_from_interrupt_instr), .forced_long_call_o(forced_long_call),
    .forced_long_call_busy_o(busy), .vector_o(vec), .in_service_o(isv)
  );
  cic_cpu_model cpu (
    .core_clk_i(clk), .sys_rst_i(rst), .busy_i(busy), .return_from_interrupt_instr_req_i(return_from_interrupt_instr_req),
    .instr_start_o(istart), .return_from_interrupt_instr_o(return_from_interrupt_instr)
  );
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask
  // pins stay low until the next return so the synchroniser sees the edge
  task automatic fire(input int src);
    @(posedge clk);
    case (src)
      0: ext_n[0] <= 1'b0;
      1: tmr[0] <= 1'b1;
      2: ext_n[1] <= 1'b0;
      3: tmr[1] <= 1'b1;
      default: ser <= 1'b1;
    endcase
    @(posedge clk);
    tmr <= 2'h0;
    ser <= 1'b0;
  endtask
  task automatic wait_call(input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(negedge clk);
      hit = forced_long_call === 1'b1;
    end
  endtask
  task automatic take(input logic [15:0] vexp, input logic [3:0] sexp);
    logic hit;
    wait_call(300, hit);
    if (!hit)
    begin
      errors++;
      $display("Error forced call expected 1 seen 0");
      end_sim();
    end
    else
    begin
      chk("vector", vexp, vec);
      chk("in service", {12'h000, sexp}, {12'h000, isv});
    end
  endtask
  task automatic ret();
    @(posedge clk);
    return_from_interrupt_instr_req <= 1'b1;
    ext_n    <= 2'h3;
    @(posedge clk);
    return_from_interrupt_instr_req <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_regs();
    rd(8'hA8, 8'h00, "enable reset");
    rd(8'h55, 8'h00, "unmapped read");
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'hDF, "enable readback");
    wr(8'hA8, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_flags();
    @(posedge clk);
    ext_n <= 2'h0;
    tmr   <= 2'h3;
    ser   <= 1'b1;
    per   <= 4'hF;
    mux   <= 3'h7;
    @(posedge clk);
    tmr   <= 2'h0;
    ser   <= 1'b0;
    per   <= 4'h0;
    mux   <= 3'h0;
    repeat (6) @(posedge clk);
    rd(8'hC0, 8'hFF, "flags low");
    rd(8'hC1, 8'h0F, "flags high");
    ext_n <= 2'h3;
    wr(8'hC0, 8'h00);
    wr(8'hC1, 8'h00);
    rd(8'hC0, 8'h00, "flags cleared");
    $display("t_flags done");
  endtask
  task automatic t_mask();
    wr(8'hA8, 8'h02);
    fire(1);
    wait_call(60, seen);
    chk("call while masked", 16'h0000, {15'h0000, seen});
    rd(8'hC0, 8'h02, "pending flag");
    wr(8'hA8, 8'h82);
    take(16'h000B, 4'h1);
    rd(8'hC0, 8'h00, "flag after ack");
    ret();
    chk("service after return", 16'h0000, {12'h000, isv});
    $display("t_mask done");
  endtask
  task automatic t_vectors();
    for (int s = 0; s < 5; s++)
    begin
      wr(8'hA8, 8'hC0 | (8'h01 << s));
      fire(s);
      take(16'h0003 + 16'h0008 * 16'(s), 4'h1);
      wr(8'hC0, 8'h00);
      ret();
    end
    $display("t_vectors done");
  endtask
  task automatic t_prio();
    wr(8'hA9, 8'h84);
    wr(8'hA8, 8'h8A);
    fire(1);
    take(16'h000B, 4'h2);
    fire(3);
    take(16'h001B, 4'h6);
    fire(1);
    wait_call(150, seen);
    chk("equal level taken", 16'h0000, {15'h0000, seen});
    ret();
    chk("service after return", 16'h0002, {12'h000, isv});
    // the pending request is taken a few clocks after the return, so watch at once
    @(posedge clk);
    return_from_interrupt_instr_req <= 1'b1;
    ext_n    <= 2'h3;
    @(posedge clk);
    return_from_interrupt_instr_req <= 1'b0;
    take(16'h000B, 4'h2);
    ret();
    chk("service cleared", 16'h0000, {12'h000, isv});
    wr(8'hA9, 8'h00);
    $display("t_prio done");
  endtask
  // merged source nine through the second and third enable registers
  task automatic t_merged();
    wr(8'hB8, 8'h10);
    wr(8'h9A, 8'h01);
    wr(8'hA8, 8'h80);
    @(posedge clk);
    mux <= 3'h1;
    @(posedge clk);
    mux <= 3'h0;
    take(16'h004B, 4'h1);
    rd(8'hC3, 8'h11, "service register");
    wr(8'hC1, 8'h00);
    ret();
    chk("service after merged return", 16'h0000, {12'h000, isv});
    wr(8'h9A, 8'h00);
    wr(8'hB8, 8'h00);
    $display("t_merged done");
  endtask
  task automatic t_wake();
    wr(8'hA8, 8'h00);
    wr(8'hC2, 8'h01);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (500) @(posedge clk);
    rd(8'hC0, 8'h00, "wake flag early");
    repeat (20) @(posedge clk);
    rd(8'hC0, 8'h01, "wake flag late");
    $display("t_wake done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_flags();
    t_mask();
    t_vectors();
    t_prio();
    t_merged();
    t_wake();
    end_sim();
  end
endmodule // cic_core_tb

// file: tb/cic_cpu_model.sv
// behavioural processor sequencer: instruction starts and returns from service
`timescale 1ns/1ps
module cic_cpu_model (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  // controller side
  input  wire logic busy_i,
  input  wire logic return_from_interrupt_instr_req_i,
  output logic      instr_start_o,
  output logic      return_from_interrupt_instr_o
);
  logic [1:0] ph_ff;
  logic       pend_ff;
  wire        slot = ph_ff == 2'h2;
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ph_ff         <= 2'h0;
      pend_ff       <= 1'b0;
      instr_start_o <= 1'b0;
      return_from_interrupt_instr_o        <= 1'b0;
    end
    else
    begin
      ph_ff         <= ph_ff + 2'h1;
      // the forced call owns the core, so no instruction starts meanwhile
      instr_start_o <= ph_ff == 2'h0 && !busy_i;
      // returns land off the start slot so they never meet a take
      return_from_interrupt_instr_o        <= slot && (pend_ff || return_from_interrupt_instr_req_i);
      pend_ff       <= (pend_ff || return_from_interrupt_instr_req_i) && !slot;
    end
  end
endmodule // cic_cpu_model
